// ---- bench/pms_supply_model.sv ----
`timescale 1ns/1ps
module pms_supply_model #(
  parameter int unsigned STEP_MV = 200
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // bench controls
  input  wire logic por_drop,
  input  wire logic ext_rst_req,
  // supply and reset pins
  output logic      analog_supply_por_ok,
  output logic      ext_reset_pin_n
);
  int unsigned vin_mv;

  // slow regulator input ramp, the case where the board must help
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) vin_mv <= 0;
    else if (vin_mv < 3300) vin_mv <= vin_mv + STEP_MV;
  end

  // pin held low until input passes 1.6 V
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) ext_reset_pin_n <= 1'b0;
    else ext_reset_pin_n <= (vin_mv > 1600) && !ext_rst_req;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) analog_supply_por_ok <= 1'b0;
    else analog_supply_por_ok <= (vin_mv > 1600) && !por_drop;
  end
endmodule // pms_supply_model

// ---- bench/power_mode_startup_sequencer_test.sv ----
`timescale 1ns/1ps
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin err_total++; \
  $display("[ERR] t=%0t got=%0h exp=%0h", $time, (a), (e)); end end
module power_mode_startup_sequencer_test;
  import pms_pkg::*;
  localparam int unsigned STAB = 4;
  // stimulus
  logic             clk = 1'b0;
  logic             rst_n = 1'b1;
  logic             core_supply_brownout_trip = 1'b0, regulator_mode_pin = 1'b1, psave_req = 1'b0;
  logic             wake_event = 1'b0, run_mode_wr = 1'b0, power_scale_wr = 1'b0, fast_clk_req = 1'b0;
  logic             fll_req = 1'b0, pll_req = 1'b0, clk_div_req = 1'b0, clk_src_alt_req = 1'b0;
  logic             lcd_enable = 1'b0, por_drop = 1'b0, ext_rst_req = 1'b0;
  logic [1:0]       sleep_gate_lvl = 2'h0;
  logic [SEG_W-1:0] lcd_seg_count = 6'h00;
  pms_psave_t       psave_sel = PSAVE_SLEEP;
  pms_run_t         run_mode_req = 2'h0;
  pms_ps_t          power_scale_req = POWER_SCALE_ZERO;
  // observed
  logic             analog_supply_por_ok, ext_reset_pin_n, cpu_reset_n, cpu_halt, clk_src_rc_sel;
  logic             system_rc_osc_en, freq_locked_loop_en, pll_en, clk_div_active, fast_clk_en, cpu_clk_en;
  logic             ahb_clk_en, apb_clk_en, core_power_on, backup_power_on, io_config_hold;
  logic             regulator_switching, brownout_monitor_en, analog_supply_por_active;
  logic [31:0]      reset_vector;
  pms_ps_t          power_scale;
  pms_run_t         run_mode;
  logic [2:0]       lcd_cluster_lcd, gpio_avail, lcd_exp;
  int               err_total = 0;
  int               n_compared = 0;
  int               n_wait;
  logic [31:0]      rng = 32'hEBA3C755;

  pms_supply_model supply_u (.clk, .rst_n, .por_drop, .ext_rst_req, .analog_supply_por_ok, .ext_reset_pin_n);
  pms_seq #(.STAB_CYCLES(STAB)) dut_u (
    .clk, .rst_n, .analog_supply_por_ok, .ext_reset_pin_n, .core_supply_brownout_trip, .regulator_mode_pin,
    .psave_req, .psave_sel, .sleep_gate_lvl, .wake_event, .run_mode_wr, .run_mode_req, .power_scale_wr,
    .power_scale_req, .fast_clk_req, .fll_req, .pll_req, .clk_div_req, .clk_src_alt_req, .lcd_enable,
    .lcd_seg_count, .cpu_reset_n, .cpu_halt, .reset_vector, .clk_src_rc_sel, .system_rc_osc_en,
    .freq_locked_loop_en, .pll_en, .clk_div_active, .fast_clk_en, .cpu_clk_en, .ahb_clk_en, .apb_clk_en,
    .core_power_on, .backup_power_on, .io_config_hold, .regulator_switching, .brownout_monitor_en,
    .analog_supply_por_active, .power_scale, .run_mode, .lcd_cluster_lcd, .gpio_avail
  );

  always #12.5 clk = ~clk;

  function automatic logic [31:0] xs();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction

  // bit order C, B, A
  function automatic logic [2:0] exp_lcd(input logic en, input logic [5:0] c);
    return en ? {c > 6'h20, c > 6'h18, 1'b1} : 3'h0;
  endfunction

  task automatic complete_run();
    $display("compared=%0d mismatches=%0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  // bounded wait on the cpu reset line; a hang ends the run
  task automatic wait_cpu(input logic want);
    n_wait = 0;
    do begin
      @(posedge clk);
      #1;
      n_wait++;
    end while (cpu_reset_n !== want && n_wait < 200);
    if (cpu_reset_n !== want) begin
      err_total++;
      complete_run();
    end
  endtask

  task automatic chk_start();
    `CHK(clk_src_rc_sel, 1'b1)
    `CHK(system_rc_osc_en, 1'b1)
    `CHK({freq_locked_loop_en, pll_en}, 2'h0)
    `CHK(clk_div_active, 1'b0)
    `CHK({power_scale, fast_clk_en}, 3'h0)
    `CHK(reset_vector, 32'h00000000)
    `CHK(run_mode, 2'h0)
    `CHK({cpu_clk_en, cpu_halt}, 2'h2)
    `CHK(brownout_monitor_en, 1'b1)
    `CHK(analog_supply_por_active, 1'b1)
    `CHK(regulator_switching, regulator_mode_pin)
  endtask

  task automatic enter(input pms_psave_t sel, input logic [1:0] lvl, input pms_run_t rm);
    cyc(1);
    run_mode_wr <= 1'b1;
    run_mode_req <= rm;
    cyc(1);
    run_mode_wr <= 1'b0;
    psave_req <= 1'b1;
    psave_sel <= sel;
    sleep_gate_lvl <= lvl;
    cyc(1);
    psave_req <= 1'b0;
    #1;
  endtask

  task automatic psave_round(input pms_psave_t sel, input logic [1:0] lvl, input pms_run_t rm);
    enter(sel, lvl, rm);
    `CHK({cpu_halt, cpu_clk_en}, 2'h2)
    `CHK(io_config_hold, 1'b1)
    `CHK(run_mode, (sel == PSAVE_BACKUP) ? 2'h0 : rm)
    if (sel == PSAVE_SLEEP) begin
      `CHK({ahb_clk_en, apb_clk_en}, {lvl == 2'h0, lvl < 2'h2})
    end else if (sel == PSAVE_BACKUP) begin
      `CHK({core_power_on, backup_power_on}, 2'h1)
    end else begin
      `CHK({system_rc_osc_en, ahb_clk_en, apb_clk_en}, 3'h0)
    end
    // wake straight after entry is the tight case
    wake_event <= 1'b1;
    cyc(1);
    wake_event <= 1'b0;
    #1;
    `CHK({cpu_halt, io_config_hold, core_power_on}, 3'h1)
    `CHK(run_mode, rm)
  endtask

  task automatic reset_in_psave(input pms_psave_t sel, input logic use_por);
    enter(sel, 2'h0, 2'h3);
    por_drop <= use_por;
    ext_rst_req <= !use_por;
    wait_cpu(1'b0);
    cyc(1);
    por_drop <= 1'b0;
    ext_rst_req <= 1'b0;
    wait_cpu(1'b1);
    chk_start();
    `CHK(run_mode, 2'h0)
  endtask

  initial begin
    rst_n = 1'b0;
    cyc(10);
    rst_n <= 1'b1;
    wait_cpu(1'b1);
    `CHK(n_wait >= STAB, 1'b1)
    chk_start();
    $display("test startup done");
    for (int i = 0; i < 12; i++) begin
      if (i < 4) psave_round(pms_psave_t'(i), 2'(i), 2'(3 - i));
      else psave_round(pms_psave_t'(2'(xs())), 2'(xs()), 2'(xs()));
    end
    $display("test power save done");
    cyc(1);
    fast_clk_req <= 1'b1;
    cyc(3);
    #1;
    `CHK(fast_clk_en, 1'b0)
    power_scale_wr <= 1'b1;
    power_scale_req <= POWER_SCALE_ONE;
    {fll_req, pll_req, clk_div_req, clk_src_alt_req} <= 4'hF;
    cyc(1);
    power_scale_wr <= 1'b0;
    cyc(3);
    #1;
    `CHK({power_scale, fast_clk_en}, 3'h3)
    `CHK({freq_locked_loop_en, pll_en, clk_div_active, clk_src_rc_sel}, 4'hE)
    // requests stay up across the reset: start-up must still come up plain
    core_supply_brownout_trip <= 1'b1;
    regulator_mode_pin <= 1'b0;
    cyc(1);
    core_supply_brownout_trip <= 1'b0;
    wait_cpu(1'b0);
    wait_cpu(1'b1);
    chk_start();
    {fast_clk_req, fll_req, pll_req, clk_div_req, clk_src_alt_req} <= 5'h00;
    $display("test brownout done");
    reset_in_psave(PSAVE_WAIT, 1'b0);
    reset_in_psave(PSAVE_BACKUP, 1'b1);
    $display("test reset in power save done");
    for (int i = 0; i < 16; i++) begin
      cyc(1);
      lcd_enable <= (i < 8) ? 1'b1 : xs() % 2 == 0;
      lcd_seg_count <= (i < 8) ? 6'(i * 8 - (i % 2)) : 6'(xs() % 41);
      cyc(1);
      #1;
      lcd_exp = exp_lcd(lcd_enable, lcd_seg_count);
      `CHK(lcd_cluster_lcd, lcd_exp)
      `CHK(gpio_avail, ~lcd_exp)
    end
    $display("test lcd clusters done");
    complete_run();
  end
endmodule // power_mode_startup_sequencer_test

// ---- src/pms_lcd_if.sv ----
`timescale 1ns/1ps
interface pms_lcd_if;
  import pms_pkg::*;
  logic              enable;
  logic [SEG_W-1:0]  seg_count;
  logic [NUM_CL-1:0] cluster_lcd;
  modport seq (output enable, output seg_count, input cluster_lcd);
  modport map (input enable, input seg_count, output cluster_lcd);
endinterface

// ---- src/pms_lcd_map.sv ----
`timescale 1ns/1ps
module pms_lcd_map (
  pms_lcd_if.map lcd
);
  import pms_pkg::*;

  always_comb begin
    lcd.cluster_lcd = '0;
    if (lcd.enable) begin
      // cluster a always carries segment lines once enabled
      lcd.cluster_lcd[CL_A] = 1'b1;
      if (lcd.seg_count > SEG_FREE_BC) begin
        lcd.cluster_lcd[CL_B] = 1'b1;
      end
      // counts above the maximum saturate to all clusters
      if (lcd.seg_count > SEG_FREE_C) begin
        lcd.cluster_lcd[CL_C] = 1'b1;
      end
    end
  end

endmodule // pms_lcd_map

// ---- src/pms_pkg.sv ----
package pms_pkg;

  // timing
  localparam int unsigned CLK_PERIOD_PS   = 25000;
  localparam int unsigned STAB_TIME_NS    = 2000;
  localparam int unsigned STAB_CYCLES_DEF = (STAB_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  // cpu vector fetch address
  localparam logic [31:0] RESET_VECTOR = 32'h0000_0000;

  // lcd clusters and segment thresholds
  localparam int unsigned SEG_W       = 6;
  localparam int unsigned SEG_MAX_DEF = 40;
  localparam int unsigned NUM_CL      = 3;
  localparam int unsigned CL_A        = 0;
  localparam int unsigned CL_B        = 1;
  localparam int unsigned CL_C        = 2;
  localparam logic [SEG_W-1:0] SEG_FREE_BC = 6'h18;
  localparam logic [SEG_W-1:0] SEG_FREE_C  = 6'h20;
  localparam logic [NUM_CL-1:0] CL_ALL     = 3'h7;

  // sleep gating levels
  localparam logic [1:0] SLEEP_LVL_AHB = 2'h1;
  localparam logic [1:0] SLEEP_LVL_APB = 2'h2;
  localparam logic [1:0] SLEEP_LVL_SRC = 2'h3;

  typedef enum logic [2:0] {
    ST_HOLD      = 3'h0,
    ST_RUN       = 3'h1,
    ST_SLEEP     = 3'h2,
    ST_WAIT      = 3'h3,
    ST_RETENTION = 3'h4,
    ST_BACKUP    = 3'h5
  } pms_state_t;

  typedef enum logic [1:0] {
    POWER_SCALE_ZERO = 2'h0,
    POWER_SCALE_ONE  = 2'h1,
    POWER_SCALE_TWO  = 2'h2
  } pms_ps_t;

  typedef enum logic [1:0] {
    PSAVE_SLEEP     = 2'h0,
    PSAVE_WAIT      = 2'h1,
    PSAVE_RETENTION = 2'h2,
    PSAVE_BACKUP    = 2'h3
  } pms_psave_t;

  typedef logic [1:0] pms_run_t;
  localparam pms_run_t DEFAULT_RUN_MODE = 2'h0;

endpackage

// ---- src/pms_seq.sv ----
`timescale 1ns/1ps
module pms_seq #(
  parameter int unsigned STAB_CYCLES = pms_pkg::STAB_CYCLES_DEF,
  parameter int unsigned SEG_MAX     = pms_pkg::SEG_MAX_DEF
) (
  // clock and reset
  input  wire logic                         clk,
  input  wire logic                         rst_n,
  // supply monitors and pins
  input  wire logic                         analog_supply_por_ok,
  input  wire logic                         ext_reset_pin_n,
  input  wire logic                         core_supply_brownout_trip,
  input  wire logic                         regulator_mode_pin,
  // cpu power-save requests
  input  wire logic                         psave_req,
  input  wire pms_pkg::pms_psave_t          psave_sel,
  input  wire logic [1:0]                   sleep_gate_lvl,
  input  wire logic                         wake_event,
  // software clock and mode requests
  input  wire logic                         run_mode_wr,
  input  wire pms_pkg::pms_run_t            run_mode_req,
  input  wire logic                         power_scale_wr,
  input  wire pms_pkg::pms_ps_t             power_scale_req,
  input  wire logic                         fast_clk_req,
  input  wire logic                         fll_req,
  input  wire logic                         pll_req,
  input  wire logic                         clk_div_req,
  input  wire logic                         clk_src_alt_req,
  // lcd configuration
  input  wire logic                         lcd_enable,
  input  wire logic [pms_pkg::SEG_W-1:0]    lcd_seg_count,
  // cpu control
  output logic                              cpu_reset_n,
  output logic                              cpu_halt,
  output logic [31:0]                       reset_vector,
  // clock control
  output logic                              clk_src_rc_sel,
  output logic                              system_rc_osc_en,
  output logic                              freq_locked_loop_en,
  output logic                              pll_en,
  output logic                              clk_div_active,
  output logic                              fast_clk_en,
  output logic                              cpu_clk_en,
  output logic                              ahb_clk_en,
  output logic                              apb_clk_en,
  // power control
  output logic                              core_power_on,
  output logic                              backup_power_on,
  output logic                              io_config_hold,
  output logic                              regulator_switching,
  output logic                              brownout_monitor_en,
  output logic                              analog_supply_por_active,
  output pms_pkg::pms_ps_t                  power_scale,
  output pms_pkg::pms_run_t                 run_mode,
  // lcd pad clusters
  output logic [pms_pkg::NUM_CL-1:0]        lcd_cluster_lcd,
  output logic [pms_pkg::NUM_CL-1:0]        gpio_avail
);
  import pms_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  localparam int unsigned CNT_W = $clog2(STAB_CYCLES + 1);

  if (STAB_CYCLES < 1) begin : g_chk_stab
    $error("STAB_CYCLES must be at least one");
  end
  if (SEG_MAX < 1 || SEG_MAX >= (1 << SEG_W)) begin : g_chk_seg
    $error("SEG_MAX does not fit the segment count field");
  end

  pms_state_t        state_reg;
  pms_state_t        state_next;
  logic [CNT_W-1:0]  hold_cnt_reg;
  logic              hold_done;
  logic              sys_reset;
  logic              in_psave_next;
  pms_run_t          saved_run_reg;
  logic              fll_reg;
  logic              pll_reg;
  logic              div_reg;
  logic              alt_src_reg;
  logic [SEG_W-1:0]  seg_clamped;

  pms_lcd_if lcd_bus ();

  function automatic logic is_psave(input pms_state_t s);
    return (s == ST_SLEEP) || (s == ST_WAIT) || (s == ST_RETENTION) || (s == ST_BACKUP);
  endfunction

  // every whole-chip reset source acts the same way, but the brownout trip counts only once brownout_monitor_en is armed
  assign sys_reset = !analog_supply_por_ok
                   || !ext_reset_pin_n
                   || (brownout_monitor_en && core_supply_brownout_trip);

  assign hold_done     = (hold_cnt_reg == CNT_W'(STAB_CYCLES - 1));
  assign in_psave_next = is_psave(state_next);

  // sequencer
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_HOLD: begin
        if (hold_done) state_next = ST_RUN;
      end
      ST_RUN: begin
        if (psave_req) begin
          case (psave_sel)
            PSAVE_SLEEP:     state_next = ST_SLEEP;
            PSAVE_WAIT:      state_next = ST_WAIT;
            PSAVE_RETENTION: state_next = ST_RETENTION;
            default:         state_next = ST_BACKUP;
          endcase
        end
      end
      ST_SLEEP, ST_WAIT, ST_RETENTION, ST_BACKUP: begin
        if (wake_event) state_next = ST_RUN;
      end
      default: state_next = ST_HOLD;
    endcase
    if (sys_reset) state_next = ST_HOLD;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ST_HOLD;
    end else begin
      state_reg <= state_next;
    end
  end

  // stabilisation counter, restarted by every reset source
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hold_cnt_reg <= '0;
    end else if (sys_reset || state_reg != ST_HOLD) begin
      hold_cnt_reg <= '0;
    end else if (!hold_done) begin
      hold_cnt_reg <= hold_cnt_reg + CNT_W'(1);
    end
  end

  // regulator mode strap, taken when the power-up hold ends
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      regulator_switching <= 1'b0;
    end else if (state_reg == ST_HOLD && hold_done && !sys_reset) begin
      regulator_switching <= regulator_mode_pin;
    end
  end

  // brownout detector armed only after start-up
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      brownout_monitor_en <= 1'b0;
    end else begin
      brownout_monitor_en <= (state_next != ST_HOLD);
    end
  end

  // run mode and its backup-domain record
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      saved_run_reg <= DEFAULT_RUN_MODE;
    end else if (sys_reset) begin
      saved_run_reg <= DEFAULT_RUN_MODE;
    end else if (state_reg == ST_RUN && in_psave_next) begin
      saved_run_reg <= run_mode;
    end
  end

  // core-domain copy is lost in backup, so wake restores from the record
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      run_mode <= DEFAULT_RUN_MODE;
    end else if (sys_reset || state_next == ST_BACKUP) begin
      run_mode <= DEFAULT_RUN_MODE;
    end else if (is_psave(state_reg) && state_next == ST_RUN) begin
      run_mode <= saved_run_reg;
    end else if (state_reg == ST_RUN && run_mode_wr) begin
      run_mode <= run_mode_req;
    end
  end

  // power scaling
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      power_scale <= POWER_SCALE_ZERO;
    end else if (sys_reset) begin
      power_scale <= POWER_SCALE_ZERO;
    end else if (state_reg == ST_RUN && power_scale_wr) begin
      power_scale <= power_scale_req;
    end
  end

  // software clock choices, cleared by reset so start-up is plain
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fll_reg     <= 1'b0;
      pll_reg     <= 1'b0;
      div_reg     <= 1'b0;
      alt_src_reg <= 1'b0;
    end else if (sys_reset) begin
      fll_reg     <= 1'b0;
      pll_reg     <= 1'b0;
      div_reg     <= 1'b0;
      alt_src_reg <= 1'b0;
    end else if (state_reg == ST_RUN) begin
      fll_reg     <= fll_req;
      pll_reg     <= pll_req;
      div_reg     <= clk_div_req;
      alt_src_reg <= clk_src_alt_req;
    end
  end

  // clock and power enables, registered from the next state
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cpu_reset_n         <= 1'b0;
      cpu_halt            <= 1'b1;
      cpu_clk_en          <= 1'b0;
      ahb_clk_en          <= 1'b0;
      apb_clk_en          <= 1'b0;
      system_rc_osc_en    <= 1'b1;
      freq_locked_loop_en <= 1'b0;
      pll_en              <= 1'b0;
      clk_div_active      <= 1'b0;
      clk_src_rc_sel      <= 1'b1;
      fast_clk_en         <= 1'b0;
      core_power_on       <= 1'b1;
      io_config_hold      <= 1'b0;
    end else begin
      cpu_reset_n      <= (state_next != ST_HOLD);
      cpu_halt         <= (state_next != ST_RUN);
      cpu_clk_en       <= (state_next == ST_RUN);
      ahb_clk_en       <= (state_next == ST_RUN)
                        || (state_next == ST_SLEEP && sleep_gate_lvl < SLEEP_LVL_AHB);
      apb_clk_en       <= (state_next == ST_RUN)
                        || (state_next == ST_SLEEP && sleep_gate_lvl < SLEEP_LVL_APB);
      // wait and retention stop every source but the 32 kHz ones
      system_rc_osc_en <= (state_next == ST_HOLD) || (state_next == ST_RUN)
                        || (state_next == ST_SLEEP);
      freq_locked_loop_en <= fll_reg && !sys_reset && ((state_next == ST_RUN)
                        || (state_next == ST_SLEEP && sleep_gate_lvl < SLEEP_LVL_SRC));
      pll_en           <= pll_reg && !sys_reset && ((state_next == ST_RUN)
                        || (state_next == ST_SLEEP && sleep_gate_lvl < SLEEP_LVL_SRC));
      clk_div_active   <= div_reg && !sys_reset && (state_next == ST_RUN);
      clk_src_rc_sel   <= !(alt_src_reg && !sys_reset && state_next == ST_RUN);
      // higher clock needs the regulator out of its lowest scaling state
      fast_clk_en      <= fast_clk_req && (state_next == ST_RUN) && !sys_reset
                        && (((state_reg == ST_RUN && power_scale_wr) ? power_scale_req : power_scale)
                            != POWER_SCALE_ZERO);
      core_power_on    <= (state_next != ST_BACKUP);
      io_config_hold   <= in_psave_next;
    end
  end

  // always-on outputs
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      backup_power_on          <= 1'b1;
      analog_supply_por_active <= 1'b1;
      reset_vector             <= RESET_VECTOR;
    end else begin
      backup_power_on          <= 1'b1;
      analog_supply_por_active <= 1'b1;
      reset_vector             <= RESET_VECTOR;
    end
  end

  // lcd clusters
  assign seg_clamped       = (lcd_seg_count > SEG_W'(SEG_MAX)) ? SEG_W'(SEG_MAX) : lcd_seg_count;
  assign lcd_bus.enable    = lcd_enable;
  assign lcd_bus.seg_count = seg_clamped;

  pms_lcd_map u_lcd_map (
    .lcd (lcd_bus.map)
  );

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lcd_cluster_lcd <= '0;
      gpio_avail      <= CL_ALL;
    end else begin
      lcd_cluster_lcd <= lcd_bus.cluster_lcd;
      gpio_avail      <= ~lcd_bus.cluster_lcd;
    end
  end

  a_stab_length: assert property (
    (state_reg == ST_HOLD && state_next == ST_RUN) |-> hold_cnt_reg == CNT_W'(STAB_CYCLES - 1)
  ) else $error("hold left before stabilisation time");
  a_boot_scale: assert property (
    $rose(cpu_reset_n) |-> power_scale == POWER_SCALE_ZERO && clk_src_rc_sel && system_rc_osc_en
  ) else $error("boot not in scale zero on rc oscillator");
  a_fast_needs_scale: assert property (fast_clk_en |-> power_scale != POWER_SCALE_ZERO && !cpu_halt)
    else $error("fast clock in scale zero");
  a_startup_clocks: assert property (
    $rose(cpu_reset_n) |-> !freq_locked_loop_en && !pll_en && !clk_div_active
  ) else $error("loops or divider active at start-up");
  a_vector_fetch: assert property ($rose(cpu_reset_n) |-> reset_vector == RESET_VECTOR)
    else $error("wrong reset vector");
  a_por_resets: assert property (
    !analog_supply_por_ok |=> !cpu_reset_n && !brownout_monitor_en ##1 !cpu_reset_n
  ) else $error("supply drop did not reset chip");
  a_brownout_arm: assert property (brownout_monitor_en |-> cpu_reset_n)
    else $error("brownout armed during start-up");
  a_reset_default: assert property (
    sys_reset |=> run_mode == DEFAULT_RUN_MODE && saved_run_reg == DEFAULT_RUN_MODE
  ) else $error("reset left non-default run mode");
  a_psave_halts: assert property (io_config_hold |-> cpu_halt && !cpu_clk_en && cpu_reset_n)
    else $error("cpu running in power-save");
  a_sleep_clocks: assert property ((state_reg == ST_SLEEP) |-> !cpu_clk_en && system_rc_osc_en)
    else $error("sleep clocks wrong");
  a_wait_clocks: assert property (
    (state_reg == ST_WAIT || state_reg == ST_RETENTION)
      |-> !apb_clk_en && !ahb_clk_en && !system_rc_osc_en && !pll_en && core_power_on
  ) else $error("clock running in wait or retention");
  a_backup_domain: assert property ((state_reg == ST_BACKUP) |-> !core_power_on && backup_power_on)
    else $error("backup domains wrong");
  a_wake_restore: assert property (
    (state_reg == ST_RUN && psave_req && !sys_reset) ##1 (is_psave(state_reg) && wake_event && !sys_reset)
      |=> run_mode == $past(run_mode, 2) && state_reg == ST_RUN
  ) else $error("wake did not restore run mode");
  a_lcd_exclusive: assert property (
    (lcd_cluster_lcd & gpio_avail) == '0 && (lcd_cluster_lcd | gpio_avail) == CL_ALL
  ) else $error("cluster in both or neither mode");
  a_lcd_count: assert property (
    lcd_enable && lcd_seg_count <= SEG_FREE_BC |=> lcd_cluster_lcd == 3'h1
  ) else $error("small segment count took too many clusters");
  a_lcd_off: assert property (!lcd_enable |=> gpio_avail == CL_ALL)
    else $error("disabled lcd holds a cluster");

endmodule // pms_seq
